/* tmr2_pkg.sv */
// constants for the timer 2 control/status block: register addresses,
// control bit positions, reset values and prescale counts.
// assumes the core drives a byte-wide special function register port.
package tmr2_pkg;
    // ==========================================================
    // register addresses
    localparam logic [7:0] ADDR_CONTROL     = 8'h00_C8;
    localparam logic [7:0] ADDR_RELOAD_LOW  = 8'h00_CA;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h00_CB;
    localparam logic [7:0] ADDR_COUNT_LOW   = 8'h00_CC;
    localparam logic [7:0] ADDR_COUNT_HIGH  = 8'h00_CD;
    // ==========================================================
    // control register fields
    localparam int BIT_HIGH_FLAG  = 7;
    localparam int BIT_LOW_FLAG   = 6;
    localparam int BIT_LOW_IRQ_EN = 5;
    localparam int BIT_CAPTURE_EN = 4;
    localparam int BIT_SPLIT      = 3;
    localparam int BIT_RUN        = 2;
    localparam int BIT_SRC_HI     = 1;
    localparam logic [7:0] CONTROL_RESET = 8'h00_00;
    localparam logic [7:0] BYTE_RESET    = 8'h00_00;
    localparam logic [7:0] BYTE_MAX      = 8'h00_FF;
    // ==========================================================
    // source select encodings
    localparam logic [1:0] SRC_DIV12_RTC  = 2'h0;
    localparam logic [1:0] SRC_CMP_RTC    = 2'h1;
    localparam logic [1:0] SRC_DIV12_CMP  = 2'h2;
    localparam logic [1:0] SRC_RTC_CMP    = 2'h3;
    // ==========================================================
    // prescalers
    localparam int          SYS_DIVIDE  = 12;
    localparam logic [3:0]  SYS_DIV_LAST = 4'(SYS_DIVIDE - 1);
    localparam int          RTC_DIVIDE  = 8;
    localparam logic [2:0]  RTC_DIV_LAST = 3'(RTC_DIVIDE - 1);
endpackage

/* tmr2_sync_edge.sv */
// two-stage synchroniser with a rising edge pulse for one slow input.
// assumes the input is asynchronous to ref_clk_i.
`timescale 1ns/10ps
module tmr2_sync_edge (
    input  wire logic ref_clk_i,
    input  wire logic nrst_i,
    input  wire logic async_i,
    output logic      rise_o
);
    logic stage1;
    logic stage2;
    logic stage3;
    // ==========================================================
    // sync chain; only stage2 and stage3 feed the edge detector
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            rise_o <= 1'b0;
        end else begin
            stage1 <= async_i;
            stage2 <= stage1;
            stage3 <= stage2;
            rise_o <= stage2 & ~stage3;
        end
    end
endmodule // tmr2_sync_edge

/* tmr2_timer.sv */
// timer 2: control register, counter, reload registers and capture.
// assumes the core drives one byte access or one bit access per cycle.
`timescale 1ns/10ps
// What this block does
// - set high flag when split high byte rolls from 0xFF to its reload value
// - in 16-bit mode set high flag when counter overflows from 0xFFFF
// - timer irq enabled plus high flag set requests an interrupt
// - hardware never clears flags; software clears both itself
// - set low flag on every low byte roll-over in any mode
// - low irq enable plus timer irq enable: low overflow interrupts
// - capture enable bit selects capture mode, else normal counting
// - split bit gives two 8-bit reload timers, else one 16-bit
// - run bit starts and stops; in split mode gates high byte only
// - in split mode source select is one shared external clock
// - slow count sources and capture triggers are synchronised
// - select 00 div12, 01 comparator; capture trigger rtc div 8
// - select 10 div12, 11 rtc div 8; capture trigger comparator
// - control register at 0xC8, bit access, resets to all zero
// - 16-bit overflow outside capture loads the reload value
// - capture copies counter into reload and sets high flag
// - capture on comparator rise or every 8 rtc cycles
// - byte clock select 1 uses system clock, 0 the source select
module tmr2_timer (
    input  wire logic       ref_clk_i,
    input  wire logic       nrst_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic [7:0] sfr_wdata_i,
    input  wire logic       sfr_rd_i,
    input  wire logic       bit_wr_i,
    input  wire logic [2:0] bit_sel_i,
    input  wire logic       bit_val_i,
    input  wire logic       timer_irq_enable_i,
    input  wire logic       high_byte_clock_select_i,
    input  wire logic       low_byte_clock_select_i,
    input  wire logic       rtc_clk_i,
    input  wire logic       comparator0_i,
    output logic [7:0]      sfr_rdata_o,
    output logic            irq_o
);
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    logic [7:0]  timer2_control;
    logic [7:0]  counter_low_byte;
    logic [7:0]  counter_high_byte;
    logic [7:0]  reload_low_byte;
    logic [7:0]  reload_high_byte;
    logic [3:0]  sys_div;
    logic [2:0]  rtc_div;
    logic        rtc_rise;
    logic        cmp_rise;

    // ==========================================================
    // synchronised slow sources and prescalers
    tmr2_sync_edge u_rtc_sync (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .async_i   (rtc_clk_i),
        .rise_o    (rtc_rise)
    );
    tmr2_sync_edge u_cmp_sync (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .async_i   (comparator0_i),
        .rise_o    (cmp_rise)
    );

    wire logic       div12_tick = (sys_div == tmr2_pkg::SYS_DIV_LAST);
    wire logic       rtc8_tick  =
        rtc_rise && (rtc_div == tmr2_pkg::RTC_DIV_LAST);
    wire logic [1:0] src_sel    = timer2_control[1:0];
    wire logic       split      = timer2_control[tmr2_pkg::BIT_SPLIT];
    wire logic       run        = timer2_control[tmr2_pkg::BIT_RUN];
    wire logic       capture_on = timer2_control[tmr2_pkg::BIT_CAPTURE_EN];
    wire logic       low_irq_en = timer2_control[tmr2_pkg::BIT_LOW_IRQ_EN];

    // shared external tick for both bytes
    wire logic ext_tick =
        (src_sel == tmr2_pkg::SRC_CMP_RTC) ? cmp_rise :
        (src_sel == tmr2_pkg::SRC_RTC_CMP) ? rtc8_tick : div12_tick;
    // capture trigger follows the upper select bit
    wire logic cap_tick = timer2_control[tmr2_pkg::BIT_SRC_HI] ?
                          cmp_rise : rtc8_tick;
    wire logic low_tick  = low_byte_clock_select_i  | ext_tick;
    wire logic high_tick = high_byte_clock_select_i | ext_tick;

    // ==========================================================
    // counting decode
    wire logic [15:0] count16 = {counter_high_byte, counter_low_byte};
    // low byte runs freely when split, else under the run bit
    wire logic lo_adv  = split ? low_tick : (run & low_tick);
    wire logic hi_adv  = split & run & high_tick;
    wire logic lo_roll = lo_adv && (counter_low_byte == tmr2_pkg::BYTE_MAX);
    wire logic wrap16  = !split && lo_roll &&
                         (counter_high_byte == tmr2_pkg::BYTE_MAX);
    wire logic hi_roll = hi_adv && (counter_high_byte == tmr2_pkg::BYTE_MAX);
    wire logic capture = capture_on && cap_tick;
    wire logic set_high = hi_roll | wrap16 | capture;
    wire logic set_low  = lo_roll;

    wire logic wr_ctl = sfr_wr_i && hit(sfr_addr_i, tmr2_pkg::ADDR_CONTROL);
    wire logic wr_rll = sfr_wr_i && hit(sfr_addr_i, tmr2_pkg::ADDR_RELOAD_LOW);
    wire logic wr_rlh = sfr_wr_i && hit(sfr_addr_i, tmr2_pkg::ADDR_RELOAD_HIGH);
    wire logic wr_cl  = sfr_wr_i && hit(sfr_addr_i, tmr2_pkg::ADDR_COUNT_LOW);
    wire logic wr_ch  = sfr_wr_i && hit(sfr_addr_i, tmr2_pkg::ADDR_COUNT_HIGH);

    // ==========================================================
    // control register: byte or single-bit writes
    logic [7:0] sw_control;
    always_comb begin
        sw_control = timer2_control;
        if (wr_ctl) begin
            sw_control = sfr_wdata_i;
        end else if (bit_wr_i) begin
            sw_control[bit_sel_i] = bit_val_i;
        end
    end
    // hardware only ever sets the flags, and its set wins over a software clear
    wire logic [7:0] next_control = sw_control |
        {set_high, set_low, 6'h00};

    // ==========================================================
    // next counter and reload values
    // a 16-bit low roll carries into the high byte, a wrap outside capture reloads it; split bytes reload alone
    wire logic [7:0] next_low =
        wr_cl   ? sfr_wdata_i :
        // no reload on a 16-bit roll in capture mode
        (lo_roll && (split || !capture_on)) ? reload_low_byte :
        lo_adv  ? 8'(counter_low_byte + 8'h01) : counter_low_byte;
    wire logic [7:0] next_high =
        wr_ch   ? sfr_wdata_i :
        (split && hi_roll) ? reload_high_byte :
        (wrap16 && !capture_on) ? reload_high_byte :
        (split ? hi_adv : lo_roll) ? 8'(counter_high_byte + 8'h01) :
        counter_high_byte;
    wire logic [7:0] next_rll = wr_rll ? sfr_wdata_i :
        capture ? counter_low_byte : reload_low_byte;
    wire logic [7:0] next_rlh = wr_rlh ? sfr_wdata_i :
        capture ? counter_high_byte : reload_high_byte;

    wire logic [7:0] next_rdata =
        !sfr_rd_i ? 8'h00 :
        hit(sfr_addr_i, tmr2_pkg::ADDR_CONTROL)     ? timer2_control    :
        hit(sfr_addr_i, tmr2_pkg::ADDR_RELOAD_LOW)  ? reload_low_byte   :
        hit(sfr_addr_i, tmr2_pkg::ADDR_RELOAD_HIGH) ? reload_high_byte  :
        hit(sfr_addr_i, tmr2_pkg::ADDR_COUNT_LOW)   ? counter_low_byte  :
        hit(sfr_addr_i, tmr2_pkg::ADDR_COUNT_HIGH)  ? counter_high_byte :
        8'h00;
    // interrupt request from the latched flags
    wire logic next_irq = timer_irq_enable_i &
        (timer2_control[tmr2_pkg::BIT_HIGH_FLAG] |
         (low_irq_en & timer2_control[tmr2_pkg::BIT_LOW_FLAG]));

    // ==========================================================
    // state
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            timer2_control    <= tmr2_pkg::CONTROL_RESET;
            counter_low_byte  <= tmr2_pkg::BYTE_RESET;
            counter_high_byte <= tmr2_pkg::BYTE_RESET;
            reload_low_byte   <= tmr2_pkg::BYTE_RESET;
            reload_high_byte  <= tmr2_pkg::BYTE_RESET;
            sys_div           <= 4'h0;
            rtc_div           <= 3'h0;
            sfr_rdata_o       <= 8'h00;
            irq_o             <= 1'b0;
        end else begin
            timer2_control    <= next_control;
            counter_low_byte  <= next_low;
            counter_high_byte <= next_high;
            reload_low_byte   <= next_rll;
            reload_high_byte  <= next_rlh;
            sys_div           <= div12_tick ? 4'h0 : 4'(sys_div + 4'h1);
            rtc_div           <= rtc_rise ? 3'(rtc_div + 3'h1) : rtc_div;
            sfr_rdata_o       <= next_rdata;
            irq_o             <= next_irq;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    property p_split_high_roll;
        split && run && high_tick && !wr_ctl && !bit_wr_i &&
        counter_high_byte == 8'hFF |=> timer2_control[7];
    endproperty
    a_split_high_roll: assert property (p_split_high_roll)
        else $error("high flag missed on high byte roll-over");

    property p_wrap16;
        !split && run && low_tick && count16 == 16'hFFFF && !wr_ctl
        |=> timer2_control[7] && timer2_control[6];
    endproperty
    a_wrap16: assert property (p_wrap16)
        else $error("flags missed on 16-bit wrap");

    property p_irq_high;
        timer_irq_enable_i && timer2_control[7] |=> irq_o;
    endproperty
    a_irq_high: assert property (p_irq_high)
        else $error("no interrupt for high flag");

    property p_flag_hold;
        timer2_control[7] && !wr_ctl && !bit_wr_i |=> timer2_control[7];
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("high flag cleared by hardware");

    property p_low_roll;
        lo_adv && counter_low_byte == 8'hFF |=> timer2_control[6];
    endproperty
    a_low_roll: assert property (p_low_roll)
        else $error("low flag missed on low byte roll-over");

    property p_irq_low;
        timer_irq_enable_i && low_irq_en && timer2_control[6] |=> irq_o;
    endproperty
    a_irq_low: assert property (p_irq_low)
        else $error("no interrupt for low flag");

    property p_reload16;
        !split && !capture_on && run && low_tick &&
        count16 == 16'hFFFF && !wr_cl && !wr_ch
        |=> count16 == $past({reload_high_byte, reload_low_byte});
    endproperty
    a_reload16: assert property (p_reload16)
        else $error("16-bit overflow did not reload");

    property p_capture;
        capture && !wr_rll && !wr_rlh
        |=> {reload_high_byte, reload_low_byte} == $past(count16)
            && timer2_control[7];
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture did not copy counter");

    property p_high_stopped;
        split && !run && !wr_ch |=> $stable(counter_high_byte);
    endproperty
    a_high_stopped: assert property (p_high_stopped)
        else $error("high byte counted while stopped");

    property p_div12;
        div12_tick |=> !div12_tick [*8];
    endproperty
    a_div12: assert property (p_div12)
        else $error("divide by twelve tick too close");

    property p_set_wins;
        set_high && wr_ctl && !sfr_wdata_i[7] |=> timer2_control[7];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("software clear beat hardware set");

    c_split_roll: cover property (split && hi_roll);
    c_capture:    cover property (capture ##1 irq_o);
    c_low_irq:    cover property (low_irq_en && set_low ##2 irq_o);
endmodule // tmr2_timer

/* tmr2_core_model.sv */
// core model: drives the register port and comparator 0.
// assumes the bench calls one access at a time.
`timescale 1ns/10ps
module tmr2_core_model (
    input  wire logic  ref_clk_i,
    output logic [7:0] sfr_addr_o,
    output logic       sfr_wr_o,
    output logic [7:0] sfr_wdata_o,
    output logic       sfr_rd_o,
    output logic       bit_wr_o,
    output logic [2:0] bit_sel_o,
    output logic       bit_val_o,
    output logic       cmp0_o
);
    // ==========================================================
    // expected reads, oldest first: {address, data}
    logic [15:0] exp_q[$];
    initial begin
        {sfr_addr_o, sfr_wr_o, sfr_wdata_o, sfr_rd_o} = '0;
        {bit_wr_o, bit_sel_o, bit_val_o, cmp0_o} = '0;
    end
    // strobes hold one edge; each access costs two cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        sfr_addr_o  <= a;
        sfr_wdata_o <= d;
        sfr_wr_o    <= 1'b1;
        @(posedge ref_clk_i);
        sfr_wr_o    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        exp_q.push_back({a, e});
        sfr_addr_o <= a;
        sfr_rd_o   <= 1'b1;
        @(posedge ref_clk_i);
        sfr_rd_o   <= 1'b0;
    endtask
    task automatic bw(input logic [2:0] b, input logic v);
        @(posedge ref_clk_i);
        bit_sel_o <= b;
        bit_val_o <= v;
        bit_wr_o  <= 1'b1;
        @(posedge ref_clk_i);
        bit_wr_o  <= 1'b0;
    endtask
    // software clears both flags itself
    task automatic clr_flags();
        bw(3'h7, 1'b0);
        bw(3'h6, 1'b0);
    endtask
    // held long enough to pass the synchroniser
    task automatic cmp_pulse();
        @(posedge ref_clk_i);
        cmp0_o <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        cmp0_o <= 1'b0;
    endtask
endmodule // tmr2_core_model

/* test_timer2_control_status.sv */
// self-checking bench for the timer 2 block and a core model.
// assumes reads are checked through the core model's queue.
`timescale 1ns/10ps
module test_timer2_control_status;
    localparam logic [7:0] CTL = tmr2_pkg::ADDR_CONTROL;
    localparam logic [7:0] RLL = tmr2_pkg::ADDR_RELOAD_LOW;
    localparam logic [7:0] RLH = tmr2_pkg::ADDR_RELOAD_HIGH;
    localparam logic [7:0] CNL = tmr2_pkg::ADDR_COUNT_LOW;
    localparam logic [7:0] CNH = tmr2_pkg::ADDR_COUNT_HIGH;
    logic        ref_clk_i = 1'b0;
    logic        nrst_i    = 1'b0;
    logic        ie        = 1'b0;
    logic        hsel      = 1'b0;
    logic        lsel      = 1'b0;
    logic        rtc       = 1'b0;
    logic        rd_seen   = 1'b0;
    logic [7:0]  addr, wdata, rdata, v;
    logic [2:0]  bsel;
    logic        wr, rd, bwr, bval, cmp0, irq;
    logic [15:0] e;
    int          fail_count = 0;
    int          n_compared = 0;
    always #2 ref_clk_i = ~ref_clk_i;
    // slow clock unrelated in phase to the system clock
    always #61 rtc = ~rtc;
    tmr2_core_model i_core (
        .ref_clk_i(ref_clk_i), .sfr_addr_o(addr), .sfr_wr_o(wr),
        .sfr_wdata_o(wdata), .sfr_rd_o(rd), .bit_wr_o(bwr),
        .bit_sel_o(bsel), .bit_val_o(bval), .cmp0_o(cmp0));
    tmr2_timer i_dut (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sfr_addr_i(addr),
        .sfr_wr_i(wr), .sfr_wdata_i(wdata), .sfr_rd_i(rd),
        .bit_wr_i(bwr), .bit_sel_i(bsel), .bit_val_i(bval),
        .timer_irq_enable_i(ie), .high_byte_clock_select_i(hsel),
        .low_byte_clock_select_i(lsel), .rtc_clk_i(rtc),
        .comparator0_i(cmp0), .sfr_rdata_o(rdata), .irq_o(irq));
    // ==========================================================
    // compares and verdict
    task automatic chk8(input string n, input logic [7:0] x,
                        input logic [7:0] s);
        n_compared++;
        if (s !== x) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic chk_irq(input logic x);
        n_compared++;
        if (irq !== x) begin
            fail_count++;
            $display("CHECK FAILED irq_o expected %b seen %b", x, irq);
        end
    endtask
    task automatic stop_test();
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // read data stands one cycle after the taking edge
    always @(posedge ref_clk_i) begin
        rd_seen <= rd;
        if (rd_seen) begin
            e = i_core.exp_q.pop_front();
            chk8($sformatf("read %h", e[15:8]), e[7:0], rdata);
        end
    end
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        fail_count++;
        stop_test();
    end
    // ==========================================================
    // scenarios
    initial begin
        void'($urandom(32'h0000_0f7d));
        repeat (5) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        i_core.rd(CTL, tmr2_pkg::CONTROL_RESET);
        for (int k = 0; k < 4; k++)
            i_core.rd(RLL + 8'(k), 8'h00);
        i_core.rd(8'hC9, 8'h00);
        for (int b = 0; b < 8; b++) begin
            i_core.bw(3'(b), 1'b1);
            i_core.rd(CTL, 8'(1 << b));
            i_core.bw(3'(b), 1'b0);
        end
        repeat (4) begin
            v = 8'($urandom);
            i_core.wr(RLH, v);
            i_core.rd(RLH, v);
        end
        // 16-bit wrap from 0xFFF0, counting every clock
        ie   <= 1'b1;
        lsel <= 1'b1;
        i_core.wr(RLL, 8'h34);
        i_core.wr(RLH, 8'h12);
        i_core.wr(CNL, 8'hF0);
        i_core.wr(CNH, 8'hFF);
        i_core.wr(CTL, 8'h04);
        repeat (40) @(posedge ref_clk_i);
        chk_irq(1'b1);
        i_core.rd(CTL, 8'hC4);
        i_core.wr(CTL, 8'h00);
        i_core.rd(CNH, 8'h12);
        chk_irq(1'b0);
        // split: low byte runs with run clear, high byte frozen
        hsel <= 1'b1;
        i_core.wr(RLL, 8'h80);
        i_core.wr(CNH, 8'h77);
        i_core.wr(CNL, 8'hF0);
        i_core.wr(CTL, 8'h08);
        repeat (30) @(posedge ref_clk_i);
        i_core.rd(CTL, 8'h48);
        i_core.rd(CNH, 8'h77);
        chk_irq(1'b0);
        i_core.bw(3'h5, 1'b1);
        i_core.rd(CTL, 8'h68);
        chk_irq(1'b1);
        i_core.clr_flags();
        // irq_o follows the cleared flag one edge later
        repeat (2) @(posedge ref_clk_i);
        chk_irq(1'b0);
        i_core.wr(CTL, 8'h00);
        // capture on a comparator rise, select 10
        i_core.wr(CNL, 8'h00);
        i_core.wr(CNH, 8'h01);
        i_core.wr(CTL, 8'h16);
        i_core.cmp_pulse();
        repeat (6) @(posedge ref_clk_i);
        i_core.rd(CTL, 8'h96);
        i_core.rd(RLH, 8'h01);
        chk_irq(1'b1);
        i_core.wr(CTL, 8'h00);
        // split, both bytes on the shared comparator tick, select 01
        lsel <= 1'b0;
        hsel <= 1'b0;
        i_core.wr(RLL, 8'h80);
        i_core.wr(RLH, 8'h40);
        i_core.wr(CNL, 8'hFF);
        i_core.wr(CNH, 8'hFF);
        i_core.wr(CTL, 8'h0D);
        i_core.cmp_pulse();
        repeat (4) @(posedge ref_clk_i);
        i_core.rd(CTL, 8'hCD);
        i_core.rd(CNL, 8'h80);
        i_core.rd(CNH, 8'h40);
        i_core.wr(CTL, 8'h00);
        // 16-bit wrap on the rtc/8 tick, select 11; one tick per 244
        i_core.wr(RLL, 8'h34);
        i_core.wr(RLH, 8'h12);
        i_core.wr(CNL, 8'hFF);
        i_core.wr(CNH, 8'hFF);
        i_core.wr(CTL, 8'h07);
        repeat (260) @(posedge ref_clk_i);
        i_core.rd(CTL, 8'hC7);
        i_core.rd(CNH, 8'h12);
        i_core.wr(CTL, 8'h00);
        // capture on the rtc/8 trigger, counting sys/12, select 00
        i_core.wr(CNL, 8'h00);
        i_core.wr(CNH, 8'h00);
        i_core.wr(CTL, 8'h14);
        repeat (260) @(posedge ref_clk_i);
        i_core.rd(CTL, 8'h94);
        i_core.rd(RLH, 8'h00);
        i_core.wr(CTL, 8'h00);
        repeat (3) @(posedge ref_clk_i);
        stop_test();
    end
endmodule // test_timer2_control_status
